// ### src/ambient_light_backlight_control.sv
// ambient light driven backlight current selection and register file
// assumes a converter on clk answering convStart with one convDone pulse
// Notes on behaviour
// - sixteen level registers, logarithmic defaults
// - each sample picks matching level as current
// - host rewrites of levels are used afterwards
// - linearity and curve selects reset to one
// - auto gain: low gain bright, high dim
// - manual gain: low gain resistor only
// - two-bit code picks 0.5 to 2 s
// - auto polling samples every elapsed period
// - manual polling: timer never starts samples
// - track enable lets secondary follow brightness
// - four-bit high and low thresholds compared
// - dimming: above high floor, below low ceiling
// - brightening: above high ceiling, below low floor
// - tracking masks fade enable and fade initial
// - reading reports level low four, sign bit4
`timescale 1ns/100ps
`default_nettype none
module ambient_light_backlight_control #(
    parameter int pollStepCycles = backlight_pkg::POLL_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic convStart,
    input wire logic convDone,
    input wire logic [4:0] convLevel,
    output logic gainHigh,
    output logic [7:0] backlightCurrent,
    output logic [4:0] subCurrent,
    output logic subTracking,
    output logic fadeEnable,
    output logic fadeInitial,
    output logic [7:0] channelEnable,
    output logic linearSensor,
    output logic linearCurve,
    output logic [7:0] biasConfig
);
    import backlight_pkg::*;

    regbus_if bus ();

    logic [7:0] chanEn_r;
    logic [7:0] fade_r;
    logic [7:0] cfgPri_r;
    logic [7:0] cfgBias_r;
    logic [7:0] cfgPoll_r;
    logic [4:0] level_r;
    logic [7:0] lvlTbl_r [16];
    logic [7:0] subThr_r;
    logic [7:0] subCtrl_r;
    logic [31:0] pollCnt_r;
    logic busy_r;
    logic [3:0] wrIdx;
    logic [3:0] rdIdx;
    logic [3:0] sampleIdx;
    logic [7:0] selCur;
    logic [31:0] curLimit;
    logic manualTrig;
    logic timerFire;
    logic pollMode;
    logic gainManual;
    logic subEn;
    logic subDir;
    logic [3:0] thrHigh;
    logic [3:0] thrLow;

    function automatic logic inTable(input logic [7:0] a);
        return a >= ADDR_LVL_FIRST && a <= ADDR_LVL_LAST;
    endfunction

    function automatic logic [3:0] tableIdx(input logic [7:0] a);
        return 4'(a - ADDR_LVL_FIRST);
    endfunction

    // period is (code + 1) half-second steps
    function automatic logic [31:0] pollLimit(input logic [1:0] code);
        return 32'(({30'h0, code} + 32'h1) * 32'(pollStepCycles) - 32'h1);
    endfunction

    i2c_reg_port port (
        .clk(clk),
        .rst(rst),
        .scl(scl),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .bus(bus)
    );

    assign wrIdx = tableIdx(bus.addr);
    assign rdIdx = tableIdx(bus.addr);
    assign manualTrig = bus.wrStb && bus.addr == ADDR_CFG_POLL && bus.wdata[POLL_TRIG_BIT];
    assign pollMode = cfgPoll_r[POLL_MODE_BIT];
    assign gainManual = cfgPri_r[GAIN_MODE_BIT];
    assign subEn = subCtrl_r[SUB_EN_BIT];
    assign subDir = subCtrl_r[SUB_DIR_BIT];
    assign thrHigh = subThr_r[THR_HIGH_LSB +: 4];
    assign thrLow = subThr_r[THR_LOW_LSB +: 4];
    // negative readings count as the darkest level
    assign sampleIdx = convLevel[SIGN_BIT] ? 4'h0 : convLevel[3:0];
    assign selCur = lvlTbl_r[sampleIdx];
    assign curLimit = pollLimit(cfgPoll_r[POLL_CODE_LSB +: 2]);
    assign timerFire = !pollMode && pollCnt_r >= curLimit;

    // register file
    always_ff @(posedge clk) begin
        if (rst) begin
            chanEn_r <= CFG_RESET;
            fade_r <= CFG_RESET;
            cfgPri_r <= CFG_RESET;
            cfgBias_r <= CFG_RESET;
            cfgPoll_r <= CFG_RESET;
            subThr_r <= CFG_RESET;
            subCtrl_r <= CFG_RESET;
            lvlTbl_r <= LEVEL_DEFAULT;
        end else if (bus.wrStb) begin
            if (bus.addr == ADDR_CHAN_EN) begin
                chanEn_r <= bus.wdata;
            end
            if (bus.addr == ADDR_FADE) begin
                fade_r <= bus.wdata;
            end
            if (bus.addr == ADDR_CFG_PRI) begin
                cfgPri_r <= bus.wdata;
            end
            if (bus.addr == ADDR_CFG_BIAS) begin
                cfgBias_r <= bus.wdata;
            end
            if (bus.addr == ADDR_CFG_POLL) begin
                // trigger bit is a strobe, never stored
                cfgPoll_r <= bus.wdata & ~(8'h01 << POLL_TRIG_BIT);
            end
            if (bus.addr == ADDR_SUB_THR) begin
                subThr_r <= bus.wdata;
            end
            if (bus.addr == ADDR_SUB_CTRL) begin
                subCtrl_r <= bus.wdata;
            end
            if (inTable(bus.addr)) begin
                lvlTbl_r[wrIdx] <= bus.wdata;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        bus.rdata = 8'h00;
        if (inTable(bus.addr)) begin
            bus.rdata = lvlTbl_r[rdIdx];
        end else if (bus.addr == ADDR_CHAN_EN) begin
            bus.rdata = chanEn_r;
        end else if (bus.addr == ADDR_FADE) begin
            bus.rdata = fade_r;
        end else if (bus.addr == ADDR_CFG_PRI) begin
            bus.rdata = cfgPri_r;
        end else if (bus.addr == ADDR_CFG_BIAS) begin
            bus.rdata = cfgBias_r;
        end else if (bus.addr == ADDR_CFG_POLL) begin
            bus.rdata = cfgPoll_r;
        end else if (bus.addr == ADDR_LEVEL_RD) begin
            bus.rdata = {3'h0, level_r};
        end else if (bus.addr == ADDR_SUB_THR) begin
            bus.rdata = subThr_r;
        end else if (bus.addr == ADDR_SUB_CTRL) begin
            bus.rdata = subCtrl_r;
        end
    end

    // polling timer, held at zero in manual mode
    always_ff @(posedge clk) begin
        if (rst || pollMode || timerFire) begin
            pollCnt_r <= 32'h0;
        end else begin
            pollCnt_r <= pollCnt_r + 32'h1;
        end
    end

    // conversion request; a request while busy is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            convStart <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            convStart <= (timerFire || manualTrig) && !busy_r && !convStart;
            if (convStart) begin
                busy_r <= 1'b1;
            end else if (convDone) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level_r <= 5'h00;
        end else if (convDone) begin
            level_r <= convLevel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            backlightCurrent <= LEVEL_DEFAULT[0];
        end else if (convDone) begin
            backlightCurrent <= selCur;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gainHigh <= 1'b1;
        end else if (gainManual) begin
            gainHigh <= 1'b0;
        end else if (convDone) begin
            gainHigh <= sampleIdx < GAIN_SWITCH_LEVEL;
        end
    end

    // secondary group stepping between floor and ceiling
    always_ff @(posedge clk) begin
        if (rst) begin
            subCurrent <= SUB_FLOOR;
        end else if (subEn && convDone) begin
            if (sampleIdx > thrHigh) begin
                subCurrent <= subDir ? SUB_CEIL : SUB_FLOOR;
            end else if (sampleIdx < thrLow) begin
                subCurrent <= subDir ? SUB_FLOOR : SUB_CEIL;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fadeEnable <= 1'b0;
            fadeInitial <= 1'b0;
            subTracking <= 1'b0;
        end else begin
            fadeEnable <= fade_r[FADE_EN_BIT] && !subEn;
            fadeInitial <= fade_r[FADE_INIT_BIT] && !subEn;
            subTracking <= subEn;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            channelEnable <= 8'h00;
            linearSensor <= 1'b1;
            linearCurve <= 1'b1;
            biasConfig <= 8'h00;
        end else begin
            channelEnable <= chanEn_r;
            linearSensor <= !cfgPri_r[LINEAR_BIT];
            linearCurve <= !cfgPri_r[CURVE_BIT];
            biasConfig <= cfgBias_r;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence sampleSeen;
        convDone;
    endsequence

    sequence autoSample;
        !gainManual && convDone ##1 !gainManual;
    endsequence

    sequence subAbove;
        subEn && convDone && sampleIdx > thrHigh;
    endsequence

    sequence subBelow;
        subEn && convDone && sampleIdx < thrLow && sampleIdx <= thrHigh;
    endsequence

    a_sample_select: assert property (
        sampleSeen |=> backlightCurrent == $past(selCur))
        else $error("backlight current not taken from table");

    a_table_write: assert property (
        bus.wrStb && inTable(bus.addr) |=> lvlTbl_r[$past(wrIdx)] == $past(bus.wdata))
        else $error("level register write lost");

    a_reset_defaults: assert property (@(posedge clk)
        $fell(rst) |-> cfgPri_r == CFG_RESET && lvlTbl_r[15] == LEVEL_DEFAULT[15])
        else $error("reset values wrong");

    a_gain_auto: assert property (
        autoSample |-> gainHigh == ($past(sampleIdx) < GAIN_SWITCH_LEVEL))
        else $error("auto gain choice wrong");

    a_gain_manual: assert property (
        gainManual |=> !gainHigh)
        else $error("manual gain left high gain on");

    a_poll_fire: assert property (
        !busy_r && !convStart && !pollMode && pollCnt_r == curLimit
        |=> convStart)
        else $error("poll period elapsed without sample");

    a_manual_quiet: assert property (
        pollMode && !manualTrig |=> !convStart)
        else $error("timer sampled in manual mode");

    a_sub_above: assert property (
        subAbove |=> subCurrent == ($past(subDir) ? SUB_CEIL : SUB_FLOOR))
        else $error("secondary step above high wrong");

    a_sub_below: assert property (
        subBelow |=> subCurrent == ($past(subDir) ? SUB_FLOOR : SUB_CEIL))
        else $error("secondary step below low wrong");

    a_sub_hold: assert property (
        convDone && sampleIdx <= thrHigh && sampleIdx >= thrLow |=> $stable(subCurrent))
        else $error("secondary level moved inside band");

    a_fade_mask: assert property (
        subEn ##1 subEn |-> !fadeEnable && !fadeInitial)
        else $error("fade bits not masked");

    a_level_report: assert property (
        convDone |=> level_r == $past(convLevel))
        else $error("light level reading not updated");

    a_start_pulse: assert property (
        convStart |=> !convStart)
        else $error("conversion request longer than one cycle");

    a_fade_pass: assert property (
        !subEn ##1 !subEn |-> fadeEnable == $past(fade_r[FADE_EN_BIT]))
        else $error("fade enable not passed through");

    a_sub_idle: assert property (
        !subEn |=> $stable(subCurrent))
        else $error("secondary level moved without tracking");
endmodule
`default_nettype wire

// ### src/backlight_pkg.sv
// constants, register map and types for the ambient backlight block
// assumes a 100 MHz clock and the register port of i2c_reg_port
package backlight_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h60;
    localparam logic [7:0] ADDR_CHAN_EN = 8'h00;
    localparam logic [7:0] ADDR_FADE = 8'h0d;
    localparam logic [7:0] ADDR_CFG_PRI = 8'h0e;
    localparam logic [7:0] ADDR_CFG_BIAS = 8'h0f;
    localparam logic [7:0] ADDR_CFG_POLL = 8'h10;
    localparam logic [7:0] ADDR_LEVEL_RD = 8'h11;
    localparam logic [7:0] ADDR_LVL_FIRST = 8'h12;
    localparam logic [7:0] ADDR_LVL_LAST = 8'h21;
    localparam logic [7:0] ADDR_SUB_THR = 8'h22;
    localparam logic [7:0] ADDR_SUB_CTRL = 8'h23;
    localparam int FADE_EN_BIT = 0;
    localparam int FADE_INIT_BIT = 1;
    localparam int GAIN_MODE_BIT = 1;
    localparam int CURVE_BIT = 2;
    localparam int LINEAR_BIT = 3;
    localparam int POLL_CODE_LSB = 4;
    localparam int POLL_MODE_BIT = 6;
    localparam int POLL_TRIG_BIT = 7;
    localparam int SUB_EN_BIT = 0;
    localparam int SUB_DIR_BIT = 1;
    localparam int THR_HIGH_LSB = 4;
    localparam int THR_LOW_LSB = 0;
    localparam int SIGN_BIT = 4;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [4:0] SUB_FLOOR = 5'h00;
    localparam logic [4:0] SUB_CEIL = 5'h16;
    localparam logic [3:0] GAIN_SWITCH_LEVEL = 4'h8;
    localparam int CLK_KHZ = 100000;
    localparam int POLL_STEP_MS = 500;
    localparam int POLL_STEP_CYCLES = POLL_STEP_MS * CLK_KHZ;
    localparam logic [7:0] LEVEL_DEFAULT [16] = '{
        8'h04, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h0d, 8'h10, 8'h14,
        8'h19, 8'h20, 8'h28, 8'h33, 8'h40, 8'h50, 8'h65, 8'h7f};
    typedef enum logic [3:0] {
        I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
        I2C_DATA, I2C_DATA_ACK, I2C_SEND, I2C_MACK
    } i2c_state_t;
endpackage

// ### src/i2c_reg_port.sv
// two-wire serial slave with register pointer and auto-increment
// assumes scl and sda arrive asynchronously; sda pad is open drain
`timescale 1ns/100ps
`default_nettype none
module i2c_reg_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    regbus_if.link bus
);
    import backlight_pkg::*;
    logic [1:0] sclSync_r;
    logic [1:0] sdaSync_r;
    logic sclPrev_r;
    logic sdaPrev_r;
    logic [7:0] shift_r;
    logic [3:0] bitCnt_r;
    logic [7:0] ptr_r;
    logic mack_r;
    logic wrStb_r;
    i2c_state_t state_r;
    logic sclNow;
    logic sdaNow;
    logic start;
    logic stop;
    logic rise;
    logic fall;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], scl};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            sclPrev_r <= sclSync_r[1];
            sdaPrev_r <= sdaSync_r[1];
        end
    end
    assign sclNow = sclSync_r[1];
    assign sdaNow = sdaSync_r[1];
    assign start = sclNow & sclPrev_r & sdaPrev_r & ~sdaNow;
    assign stop = sclNow & sclPrev_r & ~sdaPrev_r & sdaNow;
    assign rise = sclNow & ~sclPrev_r;
    assign fall = ~sclNow & sclPrev_r;

    always_ff @(posedge clk) begin
        sdaOut <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= I2C_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 4'h0;
            ptr_r <= 8'h00;
            mack_r <= 1'b0;
            wrStb_r <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            wrStb_r <= 1'b0;
            if (start) begin
                state_r <= I2C_ADDR;
                bitCnt_r <= 4'h0;
                sdaOe <= 1'b0;
            end else if (stop) begin
                state_r <= I2C_IDLE;
                sdaOe <= 1'b0;
            end else if (rise) begin
                if (state_r inside {I2C_ADDR, I2C_PTR, I2C_DATA}) begin
                    shift_r <= {shift_r[6:0], sdaNow};
                    bitCnt_r <= bitCnt_r + 4'h1;
                end else if (state_r == I2C_SEND) begin
                    bitCnt_r <= bitCnt_r + 4'h1;
                end else if (state_r == I2C_MACK) begin
                    mack_r <= ~sdaNow;
                end
            end else if (fall) begin
                unique case (state_r)
                    I2C_ADDR: begin
                        if (bitCnt_r == 4'h8 && shift_r[7:1] == DEV_ADDR) begin
                            sdaOe <= 1'b1;
                            state_r <= I2C_ADDR_ACK;
                        end else if (bitCnt_r == 4'h8) begin
                            state_r <= I2C_IDLE;
                        end
                    end
                    I2C_ADDR_ACK: begin
                        bitCnt_r <= 4'h0;
                        if (shift_r[0]) begin
                            shift_r <= bus.rdata;
                            sdaOe <= ~bus.rdata[7];
                            state_r <= I2C_SEND;
                        end else begin
                            sdaOe <= 1'b0;
                            state_r <= I2C_PTR;
                        end
                    end
                    I2C_PTR, I2C_DATA: begin
                        if (bitCnt_r == 4'h8) begin
                            sdaOe <= 1'b1;
                            bitCnt_r <= 4'h0;
                            if (state_r == I2C_PTR) begin
                                ptr_r <= shift_r;
                                state_r <= I2C_PTR_ACK;
                            end else begin
                                wrStb_r <= 1'b1;
                                state_r <= I2C_DATA_ACK;
                            end
                        end
                    end
                    I2C_PTR_ACK, I2C_DATA_ACK: begin
                        sdaOe <= 1'b0;
                        if (state_r == I2C_DATA_ACK) begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                        state_r <= I2C_DATA;
                    end
                    I2C_SEND: begin
                        if (bitCnt_r == 4'h8) begin
                            sdaOe <= 1'b0;
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= I2C_MACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sdaOe <= ~shift_r[6];
                        end
                    end
                    I2C_MACK: begin
                        bitCnt_r <= 4'h0;
                        if (mack_r) begin
                            shift_r <= bus.rdata;
                            sdaOe <= ~bus.rdata[7];
                            state_r <= I2C_SEND;
                        end else begin
                            state_r <= I2C_IDLE;
                        end
                    end
                    I2C_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    default: state_r <= I2C_IDLE;
                endcase
            end
        end
    end

    assign bus.wrStb = wrStb_r;
    assign bus.addr = ptr_r;
    assign bus.wdata = shift_r;
endmodule
`default_nettype wire

// ### src/regbus_if.sv
// register access between the serial port and the register file
// assumes both ends share clk
`timescale 1ns/100ps
`default_nettype none
interface regbus_if;
    logic wrStb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport link (output wrStb, output addr, output wdata, input rdata);
    modport regs (input wrStb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### test/ambient_light_backlight_control_bench.sv
// self-checking bench for the ambient backlight block
// assumes a converter answering each start three clocks later
`timescale 1ns/100ps
`default_nettype none
module ambient_light_backlight_control_bench;
    import backlight_pkg::*;
    logic clk, rst, convDone, sdaOut, sdaOe, convStart, gainHigh, subTracking;
    logic fadeEnable, fadeInitial, linearSensor, linearCurve;
    logic [4:0] convLevel, lvl, subCurrent;
    logic [7:0] backlightCurrent, channelEnable, biasConfig, rd;
    wire logic scl;
    wire logic sdaPull;
    wire logic sdaLine;
    int n_errors = 0, n_tests = 0, nStart = 0, nDone = 0, lastStart = 0, gap = 0, cyc = 0;
    logic [4:0] sl [9] = '{5'd2, 5'd5, 5'd10, 5'd11, 5'd3, 5'd2, 5'd11, 5'd10, 5'd2};
    logic [4:0] se [9];
    assign sdaLine = ~(sdaPull | sdaOe);
    ambient_light_backlight_control #(.pollStepCycles(20)) u_ambient_light_backlight_control (
        .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .convStart(convStart), .convDone(convDone), .convLevel(convLevel),
        .gainHigh(gainHigh), .backlightCurrent(backlightCurrent), .subCurrent(subCurrent),
        .subTracking(subTracking), .fadeEnable(fadeEnable), .fadeInitial(fadeInitial),
        .channelEnable(channelEnable), .linearSensor(linearSensor),
        .linearCurve(linearCurve), .biasConfig(biasConfig));
    i2c_host_model u_i2c_host_model (.clk(clk), .scl(scl), .sdaPull(sdaPull),
        .sdaLine(sdaLine));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // converter: one done per start
    always begin
        @(posedge clk);
        #1;
        if (convStart === 1'b1) begin
            nStart++;
            gap = cyc - lastStart;
            lastStart = cyc;
            repeat (3) @(posedge clk);
            #1 convDone = 1'b1;
            convLevel = lvl;
            @(posedge clk);
            #1 convDone = 1'b0;
            convLevel = ~lvl;
            nDone++;
        end
    end
    task automatic results();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitUntil(input bit useDone, input int target);
        for (int i = 0; i < 1000 && (useDone ? nDone : nStart) < target; i++) @(posedge clk);
        if ((useDone ? nDone : nStart) < target) begin
            n_errors++;
            results();
        end else begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    // manual trigger with the given converter result
    task automatic sample(input logic [4:0] l);
        int d0;
        d0 = nDone;
        lvl = l;
        u_i2c_host_model.regWrite(ADDR_CFG_POLL, 8'hc0);
        waitUntil(1'b1, d0 + 1);
    endtask
    initial begin
        rst = 1'b1;
        convDone = 1'b0;
        convLevel = 5'h00;
        lvl = 5'h00;
        se = '{SUB_CEIL, SUB_CEIL, SUB_CEIL, SUB_FLOOR, SUB_FLOOR, SUB_CEIL, SUB_CEIL,
            SUB_CEIL, SUB_FLOOR};
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(backlightCurrent, LEVEL_DEFAULT[0]);
        check({4'h0, linearSensor, linearCurve, gainHigh, subTracking}, 8'h0e);
        for (int i = 0; i < 16; i++) begin
            u_i2c_host_model.regRead(ADDR_LVL_FIRST + 8'(i), rd);
            check(rd, LEVEL_DEFAULT[i]);
        end
        u_i2c_host_model.regRead(ADDR_CFG_PRI, rd);
        check(rd, CFG_RESET);
        u_i2c_host_model.regRead(8'h30, rd);
        check(rd, 8'h00);
        for (int c = 0; c < 4; c++) begin
            u_i2c_host_model.regWrite(ADDR_CFG_POLL, 8'(c << POLL_CODE_LSB));
            waitUntil(1'b0, nStart + 2);
            check(8'(gap >= (c + 1) * 20 && gap <= (c + 1) * 20 + 8),
                8'h01);
        end
        u_i2c_host_model.regWrite(ADDR_CFG_POLL, 8'h40);
        gap = nStart;
        repeat (300) @(posedge clk);
        #1;
        check(8'(nStart - gap), 8'h00);
        for (int i = 0; i < 16; i++) begin
            sample(5'(i));
            check(backlightCurrent, LEVEL_DEFAULT[i]);
            check(8'(gainHigh), 8'(i < 8));
        end
        sample(5'h1a);
        check(backlightCurrent, LEVEL_DEFAULT[0]);
        u_i2c_host_model.regRead(ADDR_LEVEL_RD, rd);
        check(rd, 8'h1a);
        u_i2c_host_model.regRead(ADDR_CFG_POLL, rd);
        check(rd, 8'h40);
        u_i2c_host_model.regWrite(ADDR_LVL_FIRST + 8'h05, 8'h3c);
        sample(5'h05);
        check(backlightCurrent, 8'h3c);
        u_i2c_host_model.regWrite(ADDR_CFG_PRI, 8'h0e);
        check({6'h0, linearSensor, linearCurve}, 8'h00);
        sample(5'h02);
        check(8'(gainHigh), 8'h00);
        u_i2c_host_model.regWrite(ADDR_CFG_BIAS, 8'h5a);
        check(biasConfig, 8'h5a);
        u_i2c_host_model.regWrite(ADDR_CHAN_EN, 8'hff);
        u_i2c_host_model.regWrite(ADDR_FADE, 8'h03);
        check({6'h0, fadeEnable, fadeInitial}, 8'h03);
        check(channelEnable, 8'hff);
        // dimming response, as suits keypad lighting, then brightening from k == 6
        u_i2c_host_model.regWrite(ADDR_SUB_THR, 8'ha3);
        u_i2c_host_model.regWrite(ADDR_SUB_CTRL, 8'h01);
        check({6'h0, fadeEnable, fadeInitial}, 8'h00);
        check(8'(subTracking), 8'h01);
        for (int k = 0; k < 9; k++) begin
            if (k == 6) u_i2c_host_model.regWrite(ADDR_SUB_CTRL, 8'h03);
            sample(sl[k]);
            check(8'(subCurrent), 8'(se[k]));
        end
        u_i2c_host_model.regWrite(ADDR_SUB_CTRL, 8'h00);
        check({6'h0, fadeEnable, fadeInitial}, 8'h03);
        check(8'(u_i2c_host_model.nNack), 8'h00);
        check(8'(sdaOut), 8'h00);
        results();
    end
endmodule
`default_nettype wire

// ### test/i2c_host_model.sv
// serial host that configures and reads the backlight block
// assumes an open-drain data line with a pull-up, resolved by the bench
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
    input wire logic clk,
    output logic scl,
    output logic sdaPull,
    input wire logic sdaLine
);
    import backlight_pkg::*;
    int nNack = 0;
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // third of a bit: eight clocks, well above the minimum phase
    task automatic wt();
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic start();
        sdaPull = 1'b0;
        wt();
        scl = 1'b1;
        wt();
        sdaPull = 1'b1;
        wt();
        scl = 1'b0;
        wt();
    endtask
    task automatic stop();
        sdaPull = 1'b1;
        wt();
        scl = 1'b1;
        wt();
        sdaPull = 1'b0;
        wt();
    endtask
    task automatic bitOut(input logic b, output logic r);
        sdaPull = ~b;
        wt();
        scl = 1'b1;
        wt();
        r = sdaLine;
        scl = 1'b0;
        wt();
    endtask
    task automatic sendByte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bitOut(b[i], r);
        bitOut(1'b1, r);
        if (r !== 1'b0) nNack++;
    endtask
    task automatic getByte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitOut(1'b1, r);
            b[i] = r;
        end
        bitOut(last, r);
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        start();
        sendByte({DEV_ADDR, 1'b0});
        sendByte(a);
        sendByte(d);
        stop();
    endtask
    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        start();
        sendByte({DEV_ADDR, 1'b0});
        sendByte(a);
        start();
        sendByte({DEV_ADDR, 1'b1});
        getByte(1'b1, d);
        stop();
    endtask
endmodule
`default_nettype wire
